// ==== src/ddts_defines.svh ====
// Constants for the current-test loop sequencer
`ifndef DDTS_DEFINES_SVH
`define DDTS_DEFINES_SVH
`define DDTS_BIN_W 4
`define DDTS_NUM_BINS 4'ha
`define DDTS_CNT_W 8
`define DDTS_BANK_W 3
`define DDTS_ADDR_W 16
`define DDTS_LAST_BANK 3'h7
`define DDTS_DESEL_PAIR 2'h2
`define DDTS_HALF_ONE 1'h1
`define DDTS_HIGH_NIBBLE 4'hf
`define DDTS_ADDR_HI_LSB 7
`define DDTS_ADDR_MID_LSB 3
`define DDTS_ADDR_LO_W 3
`define DDTS_MR0_BT_BIT 3
`define DDTS_MR0_BL8 2'h0
`define DDTS_MR1_RTT_NOM 3'h3
`define DDTS_MR1_RON 2'h0
`define DDTS_MR1_TERM_STROBE_OFF 1'h0
`define DDTS_MR1_OUTPUT_OFF_SET 1'h1
`define DDTS_MR1_AL0 2'h0
`define DDTS_MR2_RTT_WR 2'h2
`define DDTS_MR2_SELFREF_TEMP_OFF 1'h0
`define DDTS_SEL_ACT 2'h0
`define DDTS_SEL_PRE 2'h1
`define DDTS_SEL_DESEL 2'h2
`define DDTS_SEL_DESEL_INV 2'h3
`define DDTS_BIN0_TIMING '{8'h05, 8'h14, 8'h0f, 8'h05}
`define DDTS_BIN1_TIMING '{8'h06, 8'h15, 8'h0f, 8'h06}
`define DDTS_BIN2_TIMING '{8'h07, 8'h1b, 8'h14, 8'h07}
`define DDTS_BIN3_TIMING '{8'h08, 8'h1c, 8'h14, 8'h08}
`define DDTS_BIN4_TIMING '{8'h09, 8'h21, 8'h18, 8'h09}
`define DDTS_BIN5_TIMING '{8'h0a, 8'h22, 8'h18, 8'h0a}
`define DDTS_BIN6_TIMING '{8'h0a, 8'h26, 8'h1c, 8'h0a}
`define DDTS_BIN7_TIMING '{8'h0b, 8'h27, 8'h1c, 8'h0b}
`define DDTS_BIN8_TIMING '{8'h0d, 8'h2d, 8'h20, 8'h0d}
`define DDTS_BIN9_TIMING '{8'h0e, 8'h32, 8'h24, 8'h0e}
`endif

// ==== src/ddts_pkg.sv ====
// Types for the current-test loop sequencer
package ddts_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} ddts_state_e;
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } ddts_cmd_s;
  typedef struct packed {
    logic [7:0] rcd;
    logic [7:0] rc;
    logic [7:0] ras;
    logic [7:0] rp;
  } ddts_timing_s;
  typedef struct packed {
    logic [1:0] burst_len;
    logic burst_type;
    logic [1:0] additive_lat;
    logic [2:0] rtt_nom;
    logic [1:0] drive;
    logic termination_strobe_fn;
    logic output_buffer_off;
    logic [1:0] rtt_wr;
    logic auto_selfrefresh_temp;
  } ddts_mode_s;
endpackage : ddts_pkg

// ==== src/ddts_timing_rom.sv ====
// Speed-bin timing table in clock cycles
`include "ddts_defines.svh"
module ddts_timing_rom (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bin select
  input wire logic [3:0] bin,
  // Looked-up timing
  output ddts_pkg::ddts_timing_s timing
);
  function automatic ddts_pkg::ddts_timing_s lookup(input logic [3:0] b);
    ddts_pkg::ddts_timing_s t;
    t = `DDTS_BIN0_TIMING;
    case (b)
      4'h0: t = `DDTS_BIN0_TIMING;
      4'h1: t = `DDTS_BIN1_TIMING;
      4'h2: t = `DDTS_BIN2_TIMING;
      4'h3: t = `DDTS_BIN3_TIMING;
      4'h4: t = `DDTS_BIN4_TIMING;
      4'h5: t = `DDTS_BIN5_TIMING;
      4'h6: t = `DDTS_BIN6_TIMING;
      4'h7: t = `DDTS_BIN7_TIMING;
      4'h8: t = `DDTS_BIN8_TIMING;
      4'h9: t = `DDTS_BIN9_TIMING;
      default: t = `DDTS_BIN0_TIMING;
    endcase
    return t;
  endfunction : lookup

  // Registered so the sequencer sees a stable table
  always_ff @(posedge clk)
  begin
    if (reset)
      timing <= lookup(4'h0);
    else
      timing <= lookup(bin);
  end
endmodule : ddts_timing_rom

// ==== src/ddts_seq.sv ====
// Per-bank activate/precharge current-test loop sequencer
// What this block does
// - Program fixed eight-beat bursts for all loops.
// - Program additive latency zero for all loops.
// - Clear mode register 0 bit 3 for nibble sequential ordering.
// - Flag when the full pattern has run at least once.
// - Leave termination strobe function disabled in mode register 1.
// - Keep automatic self-refresh temperature off.
// - Enable nominal and write termination in mode registers 1 and 2.
// - Start loops only after memory initialization is complete.
// - Use per-bin activate-to-precharge and row cycle counts.
// - Four-activate, activate spacing, refresh counts are not in the table.
`include "ddts_defines.svh"
module ddts_seq (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // User control
  input wire logic start,
  input wire logic stop,
  input wire logic init_done,
  input wire logic [3:0] speed_bin,
  // User status
  output logic busy,
  output logic pattern_done,
  output ddts_pkg::ddts_mode_s mode_cfg,
  // Memory command pins
  output logic ck_en,
  output logic odt,
  output ddts_pkg::ddts_cmd_s cmd,
  output logic [2:0] bank,
  output logic [15:0] addr
);
  ddts_pkg::ddts_state_e state;
  ddts_pkg::ddts_timing_s timing;
  logic [7:0] cyc;
  logic half;
  logic [2:0] sub;
  logic [1:0] dsel;
  logic [3:0] bin_sel;

  // Bin frozen while running; a mid-loop change would skew the counts
  always_ff @(posedge clk)
  begin
    if (reset)
      bin_sel <= '0;
    else if (state == ddts_pkg::ST_IDLE)
      bin_sel <= speed_bin;
  end

  ddts_timing_rom u_rom (
    .clk(clk),
    .reset(reset),
    .bin(bin_sel),
    .timing(timing)
  );

  // Pin encodings of the four commands the loop uses
  function automatic ddts_pkg::ddts_cmd_s enc(input logic [1:0] k);
    ddts_pkg::ddts_cmd_s c;
    case (k)
      `DDTS_SEL_ACT: c = '{1'b0, 1'b0, 1'b1, 1'b1};
      `DDTS_SEL_PRE: c = '{1'b0, 1'b0, 1'b1, 1'b0};
      `DDTS_SEL_DESEL: c = '{1'b1, 1'b0, 1'b0, 1'b0};
      default: c = '{1'b1, 1'b1, 1'b1, 1'b1};
    endcase
    return c;
  endfunction : enc

  // Slot of a running cycle: activate, precharge or one of the deselects
  function automatic logic [1:0] pick(input logic [7:0] c,
                                      input logic [7:0] act_len,
                                      input logic [1:0] ph);
    logic [1:0] k;
    if (c == '0)
      k = `DDTS_SEL_ACT;
    else if (c == act_len)
      k = `DDTS_SEL_PRE;
    else if (ph < `DDTS_DESEL_PAIR)
      k = `DDTS_SEL_DESEL;
    else
      k = `DDTS_SEL_DESEL_INV;
    return k;
  endfunction : pick

  // Last cycle of a half sub-loop
  function automatic logic slot_end(input logic [7:0] c,
                                    input logic [7:0] n);
    return c == n - 8'h01;
  endfunction : slot_end

  // Start is taken only once the memory reports itself initialised
  always_ff @(posedge clk)
  begin
    if (reset)
      state <= ddts_pkg::ST_IDLE;
    else
      case (state)
        ddts_pkg::ST_IDLE:
          if (start && init_done)
            state <= ddts_pkg::ST_RUN;
        ddts_pkg::ST_RUN:
          if (stop)
            state <= ddts_pkg::ST_IDLE;
        default:
          state <= ddts_pkg::ST_IDLE;
      endcase
  end

  // Cycle, half and bank counters; loop repeats until stopped
  always_ff @(posedge clk)
  begin
    if (reset || state != ddts_pkg::ST_RUN)
    begin
      cyc <= '0;
      half <= 1'b0;
      sub <= '0;
    end
    else if (slot_end(cyc, timing.rc))
    begin
      cyc <= '0;
      half <= ~half;
      if (half == `DDTS_HALF_ONE)
        sub <= sub + 3'h1;
    end
    else
      cyc <= cyc + 8'h01;
  end

  // Sticky until the next start seen in idle, even one held off by init_done
  always_ff @(posedge clk)
  begin
    if (reset)
      pattern_done <= 1'b0;
    else if (state == ddts_pkg::ST_IDLE && start)
      pattern_done <= 1'b0;
    else if (state == ddts_pkg::ST_RUN && sub == `DDTS_LAST_BANK
             && half == `DDTS_HALF_ONE && slot_end(cyc, timing.rc))
      pattern_done <= 1'b1;
  end

  // Deselect pair phase: two D then two D#
  always_ff @(posedge clk)
  begin
    if (reset || cyc == '0)
      dsel <= '0;
    else
      dsel <= dsel + 2'h1;
  end

  // Command pins; deselect whenever the loop is not running
  always_ff @(posedge clk)
  begin
    if (reset || state != ddts_pkg::ST_RUN)
      cmd <= enc(`DDTS_SEL_DESEL);
    else
      cmd <= enc(pick(cyc, timing.ras, dsel));
  end

  // Bank and row address follow the sub-loop and its half
  always_ff @(posedge clk)
  begin
    if (reset || state != ddts_pkg::ST_RUN)
    begin
      bank <= '0;
      addr <= '0;
    end
    else
    begin
      bank <= sub;
      addr <= '0;
      addr[`DDTS_ADDR_HI_LSB-1:`DDTS_ADDR_MID_LSB] <=
        half ? `DDTS_HIGH_NIBBLE : 4'h0;
    end
  end

  // Clock enable static high once out of reset
  always_ff @(posedge clk)
  begin
    if (reset)
      ck_en <= 1'b0;
    else
      ck_en <= 1'b1;
  end

  // Termination input is never used by the loop
  always_ff @(posedge clk)
  begin
    odt <= 1'b0;
  end

  // Busy trails the state by one edge, in step with the first activate
  always_ff @(posedge clk)
  begin
    if (reset)
      busy <= 1'b0;
    else
      busy <= state == ddts_pkg::ST_RUN;
  end

  // Mode values the controller must write before the loop
  always_ff @(posedge clk)
  begin
    if (reset)
      mode_cfg <= '0;
    else
    begin
      mode_cfg.burst_len <= `DDTS_MR0_BL8;
      mode_cfg.burst_type <= 1'b0;
      mode_cfg.additive_lat <= `DDTS_MR1_AL0;
      mode_cfg.rtt_nom <= `DDTS_MR1_RTT_NOM;
      mode_cfg.drive <= `DDTS_MR1_RON;
      mode_cfg.termination_strobe_fn <= `DDTS_MR1_TERM_STROBE_OFF;
      mode_cfg.output_buffer_off <= `DDTS_MR1_OUTPUT_OFF_SET;
      mode_cfg.rtt_wr <= `DDTS_MR2_RTT_WR;
      mode_cfg.auto_selfrefresh_temp <= `DDTS_MR2_SELFREF_TEMP_OFF;
    end
  end
endmodule : ddts_seq

// ==== tb/ddts_dram_model.sv ====
// Memory-side model tracking open rows per bank
module ddts_dram_model (
  // Pins from the sequencer
  input wire logic clk,
  input wire logic reset,
  input wire logic ck_en,
  input wire logic odt,
  input wire ddts_pkg::ddts_cmd_s cmd,
  input wire logic [2:0] bank,
  // Count of illegal commands seen
  output int faults
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] open_rows;
  initial faults = 0;
  always @(posedge clk)
  begin
    if (reset)
      open_rows <= 8'h0;
    else if (ck_en && cmd == 4'h3)
      open_rows[bank] <= 1'h1;
    else if (ck_en && cmd == 4'h2)
      open_rows[bank] <= 1'h0;
    // Activate on an open row or precharge on a closed one
    if (!reset && ck_en && (odt || open_rows[bank] != (cmd == 4'h2) &&
        (cmd == 4'h3 || cmd == 4'h2)))
      faults <= faults + 1;
  end
endmodule : ddts_dram_model

// ==== tb/ddts_seq_checker.sv ====
// Assertions on the sequencer ports
module ddts_seq_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic init_done,
  input wire logic busy,
  input wire logic ck_en,
  input wire logic odt,
  input wire ddts_pkg::ddts_cmd_s cmd,
  input wire logic [2:0] bank
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] gap;
  logic [2:0] act_bank;
  wire act = cmd == 4'h3;
  wire pre = cmd == 4'h2;
  // Plain deselect while the loop runs; idle also shows it
  wire dsl = busy && cmd == 4'h8;
  always_ff @(posedge clk)
  begin
    if (reset || act)
      gap <= 8'h1;
    else if (gap != 8'hff)
      gap <= gap + 8'h1;
  end
  always_ff @(posedge clk)
  begin
    if (act)
      act_bank <= bank;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  a_odt_low: assert property (odt == 1'h0)
    else $error("odt driven high");
  a_cke_run: assert property (busy |-> ck_en)
    else $error("clock enable low while running");
  a_act_desel: assert property (act |=> cmd == 4'h8)
    else $error("no deselect after activate");
  a_pair_swap: assert property (dsl ##1 dsl ##1 busy |-> cmd != 4'h8)
    else $error("deselect run longer than a pair");
  a_first_act: assert property ($rose(busy) |-> act && bank == 3'h0)
    else $error("run did not open with bank 0 activate");
  a_pre_bank: assert property (pre |-> bank == act_bank)
    else $error("precharge bank differs from activate");
  a_ras_min: assert property (pre |-> gap >= 8'h0f)
    else $error("precharge too soon");
  a_rc_min: assert property (act && $past(busy) |-> gap >= 8'h14)
    else $error("activates too close");
  a_init_gate: assert property ((!init_done && !busy) [*2] |=> !busy)
    else $error("ran without init");
endmodule : ddts_seq_checker
bind ddts_seq ddts_seq_checker i_chk (.clk(clk), .reset(reset),
  .init_done(init_done), .busy(busy), .ck_en(ck_en), .odt(odt),
  .cmd(cmd), .bank(bank));

// ==== tb/ddr3_current_test_sequencer_bench.sv ====
// Self-checking bench for the loop sequencer
module ddr3_current_test_sequencer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'h0, reset = 1'h1, start = 1'h0, stop = 1'h0;
  logic init_done = 1'h0, busy, pattern_done, ck_en, odt;
  logic [3:0] speed_bin = 4'h0;
  logic [2:0] bank;
  logic [15:0] addr;
  ddts_pkg::ddts_mode_s mode_cfg;
  ddts_pkg::ddts_cmd_s cmd;
  int error_cnt = 0, n_checks = 0, seed = 93193, cycles = 0, faults;
  int rc[10] = '{20, 21, 27, 28, 33, 34, 38, 39, 45, 50};
  int ras[10] = '{15, 15, 20, 20, 24, 24, 28, 28, 32, 36};
  ddts_seq i_dut (.clk(clk), .reset(reset), .start(start), .stop(stop),
    .init_done(init_done), .speed_bin(speed_bin), .busy(busy),
    .pattern_done(pattern_done), .mode_cfg(mode_cfg), .ck_en(ck_en),
    .odt(odt), .cmd(cmd), .bank(bank), .addr(addr));
  ddts_dram_model i_mem (.clk(clk), .reset(reset), .ck_en(ck_en),
    .odt(odt), .cmd(cmd), .bank(bank), .faults(faults));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Reference: {cmd, bank, addr, odt, ck_en} for every cycle of the loop
  task automatic run_bin(input int b);
    int q, e;
    speed_bin = 4'(b);
    start = 1'h1;
    @(negedge clk);
    start = 1'h0;
    for (int cy = 0; cy < 16 * rc[b] + 3; cy++)
    begin
      @(negedge clk);
      q = cy % rc[b];
      e = q == 0 ? 3 : q == ras[b] ? 2 : (q - 1) % 4 < 2 ? 8 : 15;
      e = e << 21 | (cy / (2 * rc[b])) % 8 << 18 | 1;
      e = e | ((cy / rc[b]) % 2) * 'h78 << 2;
      check({cmd, bank, addr, odt, ck_en}, e);
      if (cy == 2)
        check(pattern_done, 32'h0);
    end
    check(pattern_done, 32'h1);
    check(faults, 32'h0);
    $display("bin %0d loop done", b);
  endtask : run_bin
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      error_cnt++;
      final_report();
    end
  end
  initial
  begin
    repeat (4) @(negedge clk);
    reset = 1'h0;
    // Start must be ignored until init completes
    start = 1'h1;
    repeat (4) @(negedge clk);
    check(mode_cfg, 32'h18c);
    check({busy, cmd}, 32'h8);
    init_done = 1'h1;
    repeat (2)
    begin
      run_bin($unsigned($random(seed)) % 10);
      stop = 1'h1;
      @(negedge clk);
      stop = 1'h0;
      repeat (3) @(negedge clk);
      check(busy, 32'h0);
      reset = 1'h1;
      repeat (4) @(negedge clk);
      reset = 1'h0;
    end
    final_report();
  end
endmodule : ddr3_current_test_sequencer_bench
